// File: shared/rv_map.vh
`ifndef RV_MAP_VH
`define RV_MAP_VH

// word indices (byte address is four times), then byte addresses
`define RV_IDX_INDICATE      6'h16
`define RV_IDX_TIMING        6'h17
`define RV_IDX_FREQ          6'h18
`define RV_ADDR_STATUS       8'h80
`define RV_ADDR_MASK         8'h84
`define RV_ADDR_STATE        8'h88

// reset values
`define RV_INDICATE_RST      8'h00
`define RV_TIMING_RST        8'h2D
`define RV_FREQ_RST          8'h19
`define RV_STATUS_RST        3'h0
`define RV_MASK_RST          3'h0

// field positions
`define RV_IND_DELAY_LO_MSB  7
`define RV_IND_DELAY_LO_LSB  6
`define RV_IND_MAX_MSB       5
`define RV_TIM_DELAY_HI      7
`define RV_TIM_TIMEOUT_MSB   6
`define RV_TIM_TIMEOUT_LSB   3
`define RV_TIM_CONFIRM_MSB   2
`define RV_FRQ_ENABLE        7
`define RV_FRQ_RESERVED      6
`define RV_FRQ_ASSERT_MSB    5

// status bit positions
`define RV_ST_VALID          0
`define RV_ST_INVALID        1
`define RV_ST_END            2

// timing
`define RV_CLK_MHZ           250
`define RV_TICK_MS           11'h002
`define RV_DELAY_STEP_MS     11'h100
`define RV_TIMEOUT_STEP_MS   11'h080
`define RV_CONFIRM0_MS       11'h064
`define RV_CONFIRM1_MS       11'h096
`define RV_CONFIRM2_MS       11'h0C8
`define RV_CONFIRM3_MS       11'h100
`define RV_CONFIRM4_MS       11'h180
`define RV_CONFIRM5_MS       11'h200
`define RV_CONFIRM6_MS       11'h280
`define RV_CONFIRM7_MS       11'h400

`endif

// File: logic/rv_tick_gen.v
`timescale 1ns/1ps
module rv_tick_gen #(
  parameter CYCLES = 500000
) (
  input  wire clk_i,
  input  wire reset_i,
  output reg  tick_o
);
  reg [31:0] count_reg;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= 32'h00000000;
      tick_o    <= 1'b0;
    end else if (count_reg == CYCLES - 1) begin
      count_reg <= 32'h00000000;
      tick_o    <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h00000001;
      tick_o    <= 1'b0;
    end
  end
endmodule

// File: logic/ring_signal_validator.v
// Contract
// - valid indication delayed by 3-bit delay code
// - each crossing that is neither too fast nor too slow reloads countdown with assertion time
// - remaining count above max count: too fast
// - later crossing after countdown zero: too slow
// - both counts use 2 ms steps
// - ringing ends after 128 ms times timeout
// - valid only after whole confirmation interval
// - validation runs only while enable bit set
// - max count sets highest accepted frequency
`timescale 1ns/1ps
`include "rv_map.vh"
module ring_signal_validator #(
  parameter TICK_CYCLES = `RV_TICK_MS * `RV_CLK_MHZ * 1000
) (
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire        TIP_RING_EVENT_I,
  output reg         RING_VALID_O,
  output reg         IRQ_O,
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_QUAL  = 4'b0010;
  localparam [3:0] ST_DELAY = 4'b0100;
  localparam [3:0] ST_VALID = 4'b1000;

  localparam [1:0] RESP_OKAY   = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;

  localparam [7:0] A_IND = {`RV_IDX_INDICATE, 2'b00};
  localparam [7:0] A_TIM = {`RV_IDX_TIMING, 2'b00};
  localparam [7:0] A_FRQ = {`RV_IDX_FREQ, 2'b00};

  localparam [10:0] DELAY_STEP   = `RV_DELAY_STEP_MS / `RV_TICK_MS;
  localparam [10:0] TIMEOUT_STEP = `RV_TIMEOUT_STEP_MS / `RV_TICK_MS;
  localparam [10:0] CONF0 = `RV_CONFIRM0_MS / `RV_TICK_MS;
  localparam [10:0] CONF1 = `RV_CONFIRM1_MS / `RV_TICK_MS;
  localparam [10:0] CONF2 = `RV_CONFIRM2_MS / `RV_TICK_MS;
  localparam [10:0] CONF3 = `RV_CONFIRM3_MS / `RV_TICK_MS;
  localparam [10:0] CONF4 = `RV_CONFIRM4_MS / `RV_TICK_MS;
  localparam [10:0] CONF5 = `RV_CONFIRM5_MS / `RV_TICK_MS;
  localparam [10:0] CONF6 = `RV_CONFIRM6_MS / `RV_TICK_MS;
  localparam [10:0] CONF7 = `RV_CONFIRM7_MS / `RV_TICK_MS;

  reg  [7:0]  indicate_reg;
  reg  [7:0]  timing_reg;
  reg  [7:0]  freq_reg;
  reg  [2:0]  status_reg;
  reg  [2:0]  status_next;
  reg  [2:0]  mask_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [5:0]  timer_reg;
  reg  [5:0]  timer_next;
  reg  [10:0] quiet_reg;
  reg  [10:0] quiet_next;
  reg  [10:0] phase_reg;
  reg  [10:0] phase_next;
  reg  [10:0] confirm_ticks;
  reg         ev_valid;
  reg         ev_invalid;
  reg         ev_end;
  reg  [31:0] rdata_next;
  reg  [1:0]  rresp_next;
  wire        tick;
  wire        enable;
  wire [5:0]  assert_time;
  wire [5:0]  max_count;
  wire [2:0]  delay_code;
  wire [3:0]  timeout_code;
  wire [10:0] delay_ticks;
  wire [10:0] timeout_ticks;
  wire        too_slow;
  wire        too_fast;
  wire        wr_take;
  wire        rd_take;
  wire        status_rd;

  rv_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .tick_o  (tick)
  );

  assign enable       = freq_reg[`RV_FRQ_ENABLE];
  assign assert_time  = freq_reg[`RV_FRQ_ASSERT_MSB:0];
  assign max_count    = indicate_reg[`RV_IND_MAX_MSB:0];
  assign delay_code   = {timing_reg[`RV_TIM_DELAY_HI],
                         indicate_reg[`RV_IND_DELAY_LO_MSB:
                                      `RV_IND_DELAY_LO_LSB]};
  assign timeout_code = timing_reg[`RV_TIM_TIMEOUT_MSB:`RV_TIM_TIMEOUT_LSB];
  // delay step of 256 ms per code value
  assign delay_ticks   = {8'h00, delay_code} * DELAY_STEP;
  // timeout code 0 is treated as code 1
  assign timeout_ticks = (timeout_code == 4'h0) ? TIMEOUT_STEP :
                         {7'h00, timeout_code} * TIMEOUT_STEP;
  assign too_slow = TIP_RING_EVENT_I && (timer_reg == 6'h00);
  assign too_fast = TIP_RING_EVENT_I && (timer_reg > max_count);

  always @* begin
    case (timing_reg[`RV_TIM_CONFIRM_MSB:0])
      3'h0:    confirm_ticks = CONF0;
      3'h1:    confirm_ticks = CONF1;
      3'h2:    confirm_ticks = CONF2;
      3'h3:    confirm_ticks = CONF3;
      3'h4:    confirm_ticks = CONF4;
      3'h5:    confirm_ticks = CONF5;
      3'h6:    confirm_ticks = CONF6;
      3'h7:    confirm_ticks = CONF7;
      default: confirm_ticks = CONF0;
    endcase
  end

  // qualification engine
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    quiet_next = quiet_reg;
    phase_next = phase_reg;
    ev_valid   = 1'b0;
    ev_invalid = 1'b0;
    ev_end     = 1'b0;
    if (!enable) begin
      state_next = ST_IDLE;
      timer_next = 6'h00;
      quiet_next = 11'h000;
      phase_next = 11'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (TIP_RING_EVENT_I) begin
            state_next = ST_QUAL;
            timer_next = assert_time;
            quiet_next = 11'h000;
            phase_next = 11'h000;
          end
        end
        ST_QUAL, ST_DELAY, ST_VALID: begin
          if (too_slow || too_fast) begin
            state_next = ST_IDLE;
            ev_invalid = 1'b1;
          end else if (TIP_RING_EVENT_I) begin
            timer_next = assert_time;
            quiet_next = 11'h000;
          end else if (tick) begin
            // one decrement per 2 ms step
            if (timer_reg != 6'h00) begin
              timer_next = timer_reg - 6'h01;
            end
            quiet_next = quiet_reg + 11'h001;
          end
          if (!(too_slow || too_fast) && !TIP_RING_EVENT_I && tick &&
              (quiet_reg + 11'h001 >= timeout_ticks)) begin
            state_next = ST_IDLE;
            ev_end     = 1'b1;
          end else if (!(too_slow || too_fast)) begin
            if (state_reg == ST_QUAL) begin
              if (tick) begin
                phase_next = phase_reg + 11'h001;
              end
              if (phase_reg >= confirm_ticks) begin
                phase_next = 11'h000;
                if (delay_ticks == 11'h000) begin
                  state_next = ST_VALID;
                  ev_valid   = 1'b1;
                end else begin
                  state_next = ST_DELAY;
                end
              end
            end else if (state_reg == ST_DELAY) begin
              if (tick) begin
                phase_next = phase_reg + 11'h001;
              end
              if (phase_reg >= delay_ticks) begin
                state_next = ST_VALID;
                ev_valid   = 1'b1;
              end
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg    <= ST_IDLE;
      timer_reg    <= 6'h00;
      quiet_reg    <= 11'h000;
      phase_reg    <= 11'h000;
      RING_VALID_O <= 1'b0;
    end else begin
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      quiet_reg    <= quiet_next;
      phase_reg    <= phase_next;
      RING_VALID_O <= (state_next == ST_VALID);
    end
  end

  // register bus
  assign wr_take   = S_AXI_AWVALID_I && S_AXI_WVALID_I &&
                     !S_AXI_AWREADY_O && !S_AXI_BVALID_O;
  assign rd_take   = S_AXI_ARVALID_I && !S_AXI_ARREADY_O &&
                     !S_AXI_RVALID_O;
  assign status_rd = rd_take && (S_AXI_ARADDR_I == `RV_ADDR_STATUS);

  always @* begin
    rresp_next = RESP_OKAY;
    case (S_AXI_ARADDR_I)
      A_IND:           rdata_next = {24'h000000, indicate_reg};
      A_TIM:           rdata_next = {24'h000000, timing_reg};
      A_FRQ:           rdata_next = {24'h000000, freq_reg};
      `RV_ADDR_STATUS: rdata_next = {29'h0, status_reg};
      `RV_ADDR_MASK:   rdata_next = {29'h0, mask_reg};
      `RV_ADDR_STATE:  rdata_next = {26'h0, timer_reg == 6'h00,
                                     RING_VALID_O, state_reg};
      default: begin
        rdata_next = 32'h00000000;
        rresp_next = RESP_SLVERR;
      end
    endcase
  end

  // events win over the clear on read
  always @* begin
    status_next = status_rd ? 3'h0 : status_reg;
    status_next[`RV_ST_VALID]   = status_next[`RV_ST_VALID] | ev_valid;
    status_next[`RV_ST_INVALID] = status_next[`RV_ST_INVALID] | ev_invalid;
    status_next[`RV_ST_END]     = status_next[`RV_ST_END] | ev_end;
  end

  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      indicate_reg    <= `RV_INDICATE_RST;
      timing_reg      <= `RV_TIMING_RST;
      freq_reg        <= `RV_FREQ_RST;
      status_reg      <= `RV_STATUS_RST;
      mask_reg        <= `RV_MASK_RST;
      IRQ_O           <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= RESP_OKAY;
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h00000000;
      S_AXI_RRESP_O   <= RESP_OKAY;
    end else begin
      status_reg      <= status_next;
      IRQ_O           <= |(status_next & mask_reg);
      S_AXI_AWREADY_O <= wr_take;
      S_AXI_WREADY_O  <= wr_take;
      S_AXI_ARREADY_O <= rd_take;
      if (wr_take) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= RESP_OKAY;
        case (S_AXI_AWADDR_I)
          A_IND: begin
            if (S_AXI_WSTRB_I[0]) indicate_reg <= S_AXI_WDATA_I[7:0];
          end
          A_TIM: begin
            if (S_AXI_WSTRB_I[0]) timing_reg <= S_AXI_WDATA_I[7:0];
          end
          A_FRQ: begin
            // reserved bit held at zero
            if (S_AXI_WSTRB_I[0]) begin
              freq_reg <= S_AXI_WDATA_I[7:0] & 8'hBF;
            end
          end
          `RV_ADDR_MASK: begin
            if (S_AXI_WSTRB_I[0]) mask_reg <= S_AXI_WDATA_I[2:0];
          end
          `RV_ADDR_STATUS, `RV_ADDR_STATE: begin
          end
          default: begin
            S_AXI_BRESP_O <= RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
      if (rd_take) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O  <= rdata_next;
        S_AXI_RRESP_O  <= rresp_next;
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end
endmodule

// File: tb/rsv_checker_sva.sv
`timescale 1ns/1ps
module rsv_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire CLK_I,
  input wire RESET_I,
  input wire TIP_RING_EVENT_I,
  input wire RING_VALID_O,
  input wire S_AXI_AWVALID_I,
  input wire S_AXI_WVALID_I,
  input wire S_AXI_AWREADY_O,
  input wire S_AXI_WREADY_O,
  input wire S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire S_AXI_ARVALID_I,
  input wire S_AXI_ARREADY_O,
  input wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I
);
  localparam int QMAX = 962 * TICK_CYCLES + 4;
  localparam int CMIN = 49 * TICK_CYCLES;
  int quiet_reg;
  int age_reg;
  // cycles since last crossing and since valid was last high
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      quiet_reg <= 0;
      age_reg <= 0;
    end else begin
      quiet_reg <= TIP_RING_EVENT_I ? 0 : quiet_reg + 1;
      age_reg <= RING_VALID_O ? 0 : age_reg + 1;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_wr_take;
    S_AXI_AWVALID_I && S_AXI_WVALID_I && !S_AXI_AWREADY_O
      && !S_AXI_BVALID_O;
  endsequence
  sequence s_wr_answer;
    S_AXI_AWREADY_O && S_AXI_WREADY_O && S_AXI_BVALID_O;
  endsequence
  chk_write_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write not answered");
  chk_read_answer: assert property (S_AXI_ARVALID_I
    && !S_AXI_ARREADY_O && !S_AXI_RVALID_O
    |=> S_AXI_ARREADY_O && S_AXI_RVALID_O)
    else $error("read not answered");
  chk_wready_pulse: assert property (S_AXI_AWREADY_O
    |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write ready too long");
  chk_arready_pulse: assert property ($rose(S_AXI_ARREADY_O)
    |=> $fell(S_AXI_ARREADY_O))
    else $error("read ready too long");
  chk_bvalid_release: assert property (S_AXI_BVALID_O
    && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
    else $error("write response held");
  chk_rvalid_release: assert property (S_AXI_RVALID_O
    && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
    else $error("read response held");
  chk_end_timeout: assert property (
    RING_VALID_O |-> quiet_reg <= QMAX)
    else $error("valid ring outlives timeout");
  chk_confirm_min: assert property (
    $rose(RING_VALID_O) |-> age_reg >= CMIN)
    else $error("valid ring before confirmation");
endmodule

bind ring_signal_validator rsv_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK_I            (CLK_I),
  .RESET_I          (RESET_I),
  .TIP_RING_EVENT_I (TIP_RING_EVENT_I),
  .RING_VALID_O     (RING_VALID_O),
  .S_AXI_AWVALID_I  (S_AXI_AWVALID_I),
  .S_AXI_WVALID_I   (S_AXI_WVALID_I),
  .S_AXI_AWREADY_O  (S_AXI_AWREADY_O),
  .S_AXI_WREADY_O   (S_AXI_WREADY_O),
  .S_AXI_BVALID_O   (S_AXI_BVALID_O),
  .S_AXI_BREADY_I   (S_AXI_BREADY_I),
  .S_AXI_ARVALID_I  (S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O  (S_AXI_ARREADY_O),
  .S_AXI_RVALID_O   (S_AXI_RVALID_O),
  .S_AXI_RREADY_I   (S_AXI_RREADY_I)
);

// File: tb/ring_line_source.sv
`timescale 1ns/1ps
module ring_line_source (
  input  wire       clk_i,
  input  wire       run_i,
  input  wire [7:0] gap_i,
  output reg        event_o
);
  reg [7:0] cnt_reg;
  // one-cycle crossing every gap_i cycles while running
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt_reg <= 8'h00;
      event_o <= 1'b0;
    end else begin
      event_o <= (cnt_reg == 8'h00);
      cnt_reg <= (cnt_reg + 8'h01 >= gap_i) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule

// File: tb/ring_signal_validator_tb_top.sv
`timescale 1ns/1ps
`include "rv_map.vh"
module ring_signal_validator_tb_top;
  localparam [7:0] AI = `RV_IDX_INDICATE << 2;
  localparam [7:0] AT = `RV_IDX_TIMING << 2;
  localparam [7:0] AF = `RV_IDX_FREQ << 2;
  localparam [7:0] AS = `RV_ADDR_STATUS;
  localparam [7:0] AM = `RV_ADDR_MASK;
  localparam [7:0] AQ = `RV_ADDR_STATE;
  localparam [7:0] AU = 8'h40;
  reg         clk, rst, awv, wv, arv, run;
  reg  [7:0]  awa, ara, gap;
  reg  [31:0] wd, d;
  reg  [1:0]  r;
  wire        ev, valid, irq, awr, wrr, bv, arr, rv;
  wire [1:0]  br, rr;
  wire [31:0] rdata;
  integer     mismatches, samples_checked, seed, i;
  integer     cyc = 0;
  integer     m [0:255];
  ring_signal_validator #(.TICK_CYCLES(4)) dut (
    .CLK_I(clk), .RESET_I(rst), .TIP_RING_EVENT_I(ev),
    .RING_VALID_O(valid), .IRQ_O(irq),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(br),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(1'b1));
  ring_line_source src (.clk_i(clk), .run_i(run), .gap_i(gap),
    .event_o(ev));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task print_verdict;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  task cmp(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    awa <= a;
    wd <= {24'h000000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    @(posedge clk);
    while (awr !== 1'b1) @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    while (bv !== 1'b1) @(posedge clk);
    r = br;
    @(posedge clk);
  endtask
  task rd(input [7:0] a);
    ara <= a;
    arv <= 1'b1;
    @(posedge clk);
    while (arr !== 1'b1) @(posedge clk);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    d = rdata;
    r = rr;
    @(posedge clk);
  endtask
  // model keeps what each register should read back
  task wt(input [7:0] a, input [7:0] v);
    wr(a, v);
    cmp(r, 2'h0);
    m[a] = v & (a == AF ? 8'hBF : a == AM ? 8'h07 : 8'hFF);
  endtask
  task rt(input [7:0] a);
    rd(a);
    cmp(d, m[a]);
    cmp(r, a == AU ? 2'h2 : 2'h0);
  endtask
  task st(input [2:0] e);
    m[AS] = e;
    rt(AS);
    m[AS] = 0;
  endtask
  task ring(input integer dl);
    gap <= 8'd26 + $unsigned($random(seed)) % 9;
    run <= 1'b1;
    repeat (190 + dl) @(posedge clk);
    cmp(valid, 0);
    repeat (25) @(posedge clk);
    cmp(valid, 1);
    cmp(irq, 1);
    m[AQ] = 8'h18;
    rt(AQ);
    run <= 1'b0;
    st(3'h1);
    cmp(irq, 0);
    repeat (190) @(posedge clk);
    cmp(valid, 1);
    repeat (80) @(posedge clk);
    cmp(valid, 0);
    st(3'h4);
  endtask
  initial begin
    rst = 1'b1;
    {awv, wv, arv, run} = 4'h0;
    {awa, ara, gap, wd} = 56'h0;
    mismatches = 0;
    samples_checked = 0;
    seed = 38941;
    for (i = 0; i < 256; i = i + 1) m[i] = 0;
    m[AT] = `RV_TIMING_RST;
    m[AF] = `RV_FREQ_RST;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rt(AI);
    rt(AT);
    rt(AF);
    rt(AS);
    rt(AM);
    rt(AU);
    wr(AU, 8'h5A);
    cmp(r, 2'h2);
    wt(AI, 8'h04);
    wt(AT, 8'h08);
    wt(AM, 8'h07);
    wt(AF, 8'h8A);
    for (i = 0; i < 4; i = i + 1) rt(i == 3 ? AM : AI + 4 * i);
    ring(0);
    wt(AI, 8'h44);
    wt(AT, 8'h09);
    ring(612);
    wt(AI, 8'h04);
    wt(AT, 8'h08);
    gap <= 8'd8;
    run <= 1'b1;
    repeat (100) @(posedge clk);
    run <= 1'b0;
    cmp(valid, 0);
    st(3'h2);
    repeat (300) @(posedge clk);
    rd(AS);
    wt(AM, 8'h00);
    gap <= 8'd60;
    run <= 1'b1;
    repeat (150) @(posedge clk);
    run <= 1'b0;
    cmp(valid, 0);
    cmp(irq, 0);
    st(3'h2);
    repeat (300) @(posedge clk);
    rd(AS);
    wt(AF, 8'h0A);
    wt(AM, 8'h07);
    gap <= 8'd30;
    run <= 1'b1;
    repeat (300) @(posedge clk);
    run <= 1'b0;
    cmp(valid, 0);
    st(3'h0);
    cmp(irq, 0);
    m[AQ] = 8'h21;
    rt(AQ);
    print_verdict;
  end
endmodule
